// >>> include/dual_select_pkg.sv
// shared constants for the dual channel select and reserve arbiter
package dual_select_pkg;
    localparam int CLK_MHZ           = 100;
    localparam int CLK_PERIOD_NS     = 10;
    localparam int RESERVE_PULSE_NS  = 300;
    localparam int TRIED_PULSE_US    = 30;
    localparam int RELEASE_TIME_MS   = 500;
    localparam int SERVO_CLK_KHZ     = 9670;
    // cycle counts: minimum times round up
    localparam int RESERVE_PULSE_CYC = (RESERVE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRIED_PULSE_CYC   = TRIED_PULSE_US * 1000 / CLK_PERIOD_NS;
    localparam int RELEASE_CYC       = RELEASE_TIME_MS * 1000 * CLK_MHZ;
    // phase divider from the 100 MHz clock toward the servo clock rate
    localparam int PHASE_DIV         = (CLK_MHZ * 1000) / SERVO_CLK_KHZ;
    localparam int ADDR_W            = 4;
    localparam int BUS_W             = 10;
    localparam int TAG_W             = 3;
    localparam int BUS_RELEASE_BIT   = 9;
    localparam int BUS_PRIORITY_BIT  = 9;
    localparam int TAG_CONTROL_IDX   = 2;
    localparam int ADDR_INHIBIT_BIT  = 3;
    localparam logic [7:0] PHASE_MAX = 8'(PHASE_DIV - 1);
endpackage

// >>> rtl/pulse_timer.sv
// retriggerable down counter producing a fixed-length pulse
`timescale 1ns/1ps
module pulse_timer #(
    parameter int LEN = 30
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic start,
    output logic      active
);
    localparam int W = $clog2(LEN + 1);
    logic [W-1:0] count;

    // refuse a length the counter cannot serve
    if (LEN < 1) begin : g_len_check
        $error("pulse_timer: LEN must be at least 1");
    end

    // load on start, count down to zero
    always_ff @(posedge clk) begin
        if (srst) begin
            count <= '0;
        end else if (start) begin
            count <= W'(LEN);
        end else if (count != '0) begin
            count <= count - W'(1);
        end
    end

    assign active = (count != '0);
endmodule

// >>> rtl/dual_port_select_reserve.sv
// dual channel select, reserve, release and priority arbiter
// Behaviour
// - refuse select while other channel holds reserve
// - compare address only on select tag
// - match sets selected, 300 ns reserve pulse
// - unit selected once selected and reserved
// - deselect clears selected, keeps reservation
// - reserve holds until release, priority or timed-mode expiry
// - refused match returns unit selected plus busy
// - refused attempt sets failed attempt flag
// - other free: clear flag, seek end low 30us
// - disabled channel select fails silently
// - timer runs 500 ms past deselect, timed mode
// - absolute mode ignores timer expiry
// - expiry never clears port lockout
// - tag 3 bit 9 clears reserve and lockout
// - priority locks owner, selects requester
// - maintenance switch disables its channel
// - selected flags clocked on alternate phases
// - compare needs open cable detect active
// - lockout stays until other channel clears
`timescale 1ns/1ps
module dual_port_select_reserve
    import dual_select_pkg::*;
#(
    parameter int RELEASE_CYCLES = RELEASE_CYC,
    parameter int TRIED_CYCLES   = TRIED_PULSE_CYC,
    parameter int RESERVE_CYCLES = RESERVE_PULSE_CYC
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] plug_address,
    input  wire logic              absolute_hold_mode,
    input  wire logic              timed_hold_mode,
    input  wire logic              first_port_off_position,
    input  wire logic              second_port_off_position,
    input  wire logic [1:0]        select_tag,
    input  wire logic [1:0]        cable_present,
    input  wire logic [ADDR_W-1:0] unit_address_0,
    input  wire logic [ADDR_W-1:0] unit_address_1,
    input  wire logic [TAG_W-1:0]  tag_0,
    input  wire logic [TAG_W-1:0]  tag_1,
    input  wire logic [BUS_W-1:0]  bus_0,
    input  wire logic [BUS_W-1:0]  bus_1,
    output logic [1:0]             select_compare,
    output logic [1:0]             port_enable,
    output logic [1:0]             unit_selected,
    output logic [1:0]             busy,
    output logic [1:0]             seek_end_n,
    output logic [1:0]             failed_attempt_flag,
    output logic [1:0]             port_lockout_flag,
    output logic [1:0]             reserved
);
    logic [1:0] selected;
    logic [1:0] compare;
    logic [1:0] priority_req;
    logic [1:0] release_cmd;
    logic [1:0] owned_by_other;
    logic [1:0] disabled;
    logic [1:0] grant;
    logic [1:0] res_pulse;
    logic [1:0] res_pulse_d;
    logic [1:0] timer_run;
    logic [1:0] timer_run_d;
    logic [1:0] tried_start;
    logic [1:0] tried_active;
    logic [1:0] maint_off;
    logic [1:0] compare_d;
    logic [7:0] phase_cnt;
    logic       phase_en;
    logic       phase;

    // refuse cycle counts that the timers cannot serve
    if (RELEASE_CYCLES < 1 || TRIED_CYCLES < 1 || RESERVE_CYCLES < 1) begin : g_count_check
        $error("dual_port_select_reserve: cycle counts must be positive");
    end

    // decode address match: select tag, cable present, inhibit bit 3 clear and equal address
    function automatic logic addr_match(input logic tag, input logic cable,
                                        input logic [ADDR_W-1:0] a,
                                        input logic [ADDR_W-1:0] plug);
        addr_match = tag && cable && !a[ADDR_INHIBIT_BIT] && (a == plug);
    endfunction

    assign maint_off = {second_port_off_position, first_port_off_position};

    ////////////////////////////////////////////////////////////////////////
    // per channel decode
    always_comb begin
        compare[0] = addr_match(select_tag[0], cable_present[0],
                                unit_address_0, plug_address);
        compare[1] = addr_match(select_tag[1], cable_present[1],
                                unit_address_1, plug_address);
        priority_req[0] = compare[0] && bus_0[BUS_PRIORITY_BIT];
        priority_req[1] = compare[1] && bus_1[BUS_PRIORITY_BIT];
        release_cmd[0]  = selected[0] && tag_0[TAG_CONTROL_IDX] && bus_0[BUS_RELEASE_BIT];
        release_cmd[1]  = selected[1] && tag_1[TAG_CONTROL_IDX] && bus_1[BUS_RELEASE_BIT];
        disabled[0] = port_lockout_flag[0] || maint_off[0];
        disabled[1] = port_lockout_flag[1] || maint_off[1];
        owned_by_other[0] = selected[1] || reserved[1];
        owned_by_other[1] = selected[0] || reserved[0];
        // priority overrides ownership; plain select only when free
        grant[0] = compare[0] && !disabled[0] && (!owned_by_other[0] || priority_req[0]);
        grant[1] = compare[1] && !disabled[1] && (!owned_by_other[1] || priority_req[1]);
    end

    ////////////////////////////////////////////////////////////////////////
    // phase enable: alternating update slots for the selected flags
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_cnt <= '0;
            phase     <= 1'b0;
        end else if (phase_cnt == PHASE_MAX) begin
            phase_cnt <= '0;
            phase     <= ~phase;
        end else begin
            phase_cnt <= phase_cnt + 8'h01;
        end
    end
    assign phase_en = (phase_cnt == PHASE_MAX);

    // selected flags, each channel set only in its own phase slot, cleared in any cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            selected <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (port_lockout_flag[i] || maint_off[i] || !compare[i]) begin
                    selected[i] <= 1'b0;
                end else if (phase_en && phase == i[0] && grant[i]
                             && !selected[1-i]) begin
                    selected[i] <= 1'b1;
                end
            end
        end
    end

    // reserve pulse trigger on rising selected flag of a channel
    always_ff @(posedge clk) begin
        if (srst) begin
            compare_d   <= 2'b00;
            res_pulse_d <= 2'b00;
        end else begin
            compare_d   <= selected;
            res_pulse_d <= res_pulse;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_chan
        pulse_timer #(.LEN(RESERVE_CYCLES)) u_res (
            .clk    (clk),
            .srst   (srst),
            .start  (selected[g] && !compare_d[g]),
            .active (res_pulse[g])
        );
        pulse_timer #(.LEN(TRIED_CYCLES)) u_tried (
            .clk    (clk),
            .srst   (srst),
            .start  (tried_start[g]),
            .active (tried_active[g])
        );
        pulse_timer #(.LEN(RELEASE_CYCLES)) u_rel (
            .clk    (clk),
            .srst   (srst),
            .start  (selected[g]),
            .active (timer_run[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // reserved flags: set by leading edge of reserve pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            reserved    <= 2'b00;
            timer_run_d <= 2'b00;
        end else begin
            timer_run_d <= timer_run;
            for (int i = 0; i < 2; i++) begin
                if (res_pulse[i] && !res_pulse_d[i]) begin
                    reserved[i] <= 1'b1;
                end else if (release_cmd[i] || port_lockout_flag[i]) begin
                    reserved[i] <= 1'b0;
                end else if (timer_run_d[i] && !timer_run[i] && timed_hold_mode
                             && !absolute_hold_mode) begin
                    reserved[i] <= 1'b0;
                end
            end
        end
    end

    // lockout flags: set by the other channel's priority, cleared by its release
    always_ff @(posedge clk) begin
        if (srst) begin
            port_lockout_flag <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (grant[1-i] && priority_req[1-i] && owned_by_other[1-i]) begin
                    port_lockout_flag[i] <= 1'b1;
                end else if (release_cmd[1-i]) begin
                    port_lockout_flag[i] <= 1'b0;
                end
            end
        end
    end

    // failed attempt flags and availability notice
    always_ff @(posedge clk) begin
        if (srst) begin
            failed_attempt_flag <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (compare[i] && !disabled[i] && owned_by_other[i] && !priority_req[i]) begin
                    failed_attempt_flag[i] <= 1'b1;
                end else if (failed_attempt_flag[i] && !owned_by_other[i]) begin
                    failed_attempt_flag[i] <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            tried_start[i] = failed_attempt_flag[i] && !owned_by_other[i]
                             && !(compare[i] && owned_by_other[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // responses toward each controller
    always_ff @(posedge clk) begin
        if (srst) begin
            unit_selected  <= 2'b00;
            busy           <= 2'b00;
            seek_end_n     <= 2'b11;
            port_enable    <= 2'b00;
            select_compare <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                select_compare[i] <= compare[i] && !disabled[i];
                port_enable[i]    <= selected[i];
                busy[i]           <= compare[i] && !disabled[i] && !selected[i]
                                     && owned_by_other[i];
                unit_selected[i]  <= (selected[i] && reserved[i])
                                     || (compare[i] && !disabled[i]
                                         && owned_by_other[i]);
                seek_end_n[i]     <= !tried_active[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_never_both_selected;
        @(posedge clk) disable iff (srst) !(selected[0] && selected[1]);
    endproperty
    a_never_both_selected: assert property (p_never_both_selected)
        else $error("both channels selected");

    property p_refuse_owned;
        @(posedge clk) disable iff (srst)
            (compare[0] && reserved[1] && !priority_req[0]) |=> !selected[0];
    endproperty
    a_refuse_owned: assert property (p_refuse_owned)
        else $error("channel 0 selected while channel 1 reserved");

    property p_busy_response;
        @(posedge clk) disable iff (srst)
            (compare[1] && !disabled[1] && owned_by_other[1] && !selected[1])
            |=> busy[1] && unit_selected[1];
    endproperty
    a_busy_response: assert property (p_busy_response)
        else $error("busy not returned on refused select");

    property p_disabled_silent;
        @(posedge clk) disable iff (srst)
            (maint_off[0] && !srst) |=> ##1 (!unit_selected[0] && !busy[0]);
    endproperty
    a_disabled_silent: assert property (p_disabled_silent)
        else $error("response from disabled channel");

    property p_release_clears;
        @(posedge clk) disable iff (srst)
            release_cmd[1] && !(res_pulse[1] && !res_pulse_d[1])
            |=> !reserved[1] && !port_lockout_flag[0];
    endproperty
    a_release_clears: assert property (p_release_clears)
        else $error("release did not clear reserve and lockout");

    property p_unit_sel_needs_flags;
        @(posedge clk) disable iff (srst)
            $rose(unit_selected[0]) |-> $past(selected[0] && reserved[0])
                                        || $past(owned_by_other[0]);
    endproperty
    a_unit_sel_needs_flags: assert property (p_unit_sel_needs_flags)
        else $error("unit selected without cause");

    property p_notice_length;
        @(posedge clk) disable iff (srst)
            $fell(seek_end_n[0]) |-> !seek_end_n[0] [*8];
    endproperty
    a_notice_length: assert property (p_notice_length)
        else $error("availability notice too short");

    property p_notice_length_1;
        @(posedge clk) disable iff (srst)
            $fell(seek_end_n[1]) |-> !seek_end_n[1] [*8];
    endproperty
    a_notice_length_1: assert property (p_notice_length_1)
        else $error("availability notice too short on channel 1");

    property p_absolute_holds;
        @(posedge clk) disable iff (srst)
            (absolute_hold_mode && reserved[0] && !release_cmd[0] && !port_lockout_flag[0])
            |=> reserved[0];
    endproperty
    a_absolute_holds: assert property (p_absolute_holds)
        else $error("absolute reservation lost");

    property p_lockout_stays;
        @(posedge clk) disable iff (srst)
            (port_lockout_flag[0] && !release_cmd[1]) |=> port_lockout_flag[0];
    endproperty
    a_lockout_stays: assert property (p_lockout_stays)
        else $error("lockout cleared without release");

    c_select: cover property (@(posedge clk) disable iff (srst) $rose(unit_selected[0]));
    c_busy: cover property (@(posedge clk) disable iff (srst) $rose(busy[1]));
    c_lockout: cover property (@(posedge clk) disable iff (srst) $rose(port_lockout_flag[0]));
    c_notice: cover property (@(posedge clk) disable iff (srst) $fell(seek_end_n[1]));
endmodule

// >>> test/controller_model.sv
// behavioural controller on one channel of the dual select arbiter
`timescale 1ns/1ps
module controller_model
    import dual_select_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              want_select,
    input  wire logic              want_priority,
    input  wire logic              want_release,
    input  wire logic [ADDR_W-1:0] target,
    output logic                   select_tag,
    output logic [ADDR_W-1:0]      unit_address,
    output logic [TAG_W-1:0]       tag,
    output logic [BUS_W-1:0]       bus
);
    ////////////////////////////////////////////////////////////////////////////////
    // idle values before the first edge
    initial begin
        select_tag = 1'b0;
        unit_address = 4'h0;
        tag = 3'h0;
        bus = 10'h000;
    end

    // select tag with address; priority is select plus bus bit 9
    always @(posedge clk) begin
        select_tag <= want_select | want_priority;
        unit_address <= target;
    end

    // control tag 3 with bus bit 9 releases; low bus bits never rest
    always @(posedge clk) begin
        tag <= want_release ? 3'h4 : 3'h0;
        bus[BUS_RELEASE_BIT] <= want_priority | want_release;
        bus[8:0] <= bus[8:0] + 9'h001;
    end
endmodule

// >>> test/dual_port_select_reserve_test.sv
// self-checking bench for the dual channel select and reserve arbiter
`timescale 1ns/1ps
module dual_port_select_reserve_test
    import dual_select_pkg::*;
;
    localparam int REL = 200;
    localparam int TRY = 20;
    localparam logic [ADDR_W-1:0] PLUG = 4'h5;
    logic              clk = 1'b0;
    logic              srst = 1'b1;
    logic [ADDR_W-1:0] plug_address = PLUG;
    logic              absolute_hold_mode = 1'b1;
    logic              timed_hold_mode = 1'b0;
    logic              first_off = 1'b0;
    logic              second_off = 1'b0;
    logic [1:0]        cable_present = 2'h3;
    logic [1:0]        want_select = 2'h0;
    logic [1:0]        want_priority = 2'h0;
    logic [1:0]        want_release = 2'h0;
    logic [ADDR_W-1:0] target_0 = PLUG;
    logic [ADDR_W-1:0] target_1 = PLUG;
    logic [1:0]        select_tag;
    logic [ADDR_W-1:0] unit_address_0, unit_address_1;
    logic [TAG_W-1:0]  tag_0, tag_1;
    logic [BUS_W-1:0]  bus_0, bus_1;
    logic [1:0]        select_compare, port_enable, unit_selected, busy;
    logic [1:0]        seek_end_n, failed_attempt_flag, port_lockout_flag, reserved;
    int                errors = 0;
    int                compares = 0;
    int                cycles = 0;
    int                n;

    ////////////////////////////////////////////////////////////////////////////////
    // clock, controllers and design
    always #5 clk = ~clk;

    controller_model controller_model_inst (.clk(clk), .want_select(want_select[0]),
        .want_priority(want_priority[0]), .want_release(want_release[0]), .target(target_0),
        .select_tag(select_tag[0]), .unit_address(unit_address_0), .tag(tag_0), .bus(bus_0));
    controller_model controller_model_inst_b (.clk(clk), .want_select(want_select[1]),
        .want_priority(want_priority[1]), .want_release(want_release[1]), .target(target_1),
        .select_tag(select_tag[1]), .unit_address(unit_address_1), .tag(tag_1), .bus(bus_1));

    dual_port_select_reserve #(.RELEASE_CYCLES(REL), .TRIED_CYCLES(TRY))
    dual_port_select_reserve_inst (.clk(clk), .srst(srst), .plug_address(plug_address),
        .absolute_hold_mode(absolute_hold_mode), .timed_hold_mode(timed_hold_mode),
        .first_port_off_position(first_off), .second_port_off_position(second_off),
        .select_tag(select_tag), .cable_present(cable_present),
        .unit_address_0(unit_address_0), .unit_address_1(unit_address_1),
        .tag_0(tag_0), .tag_1(tag_1), .bus_0(bus_0), .bus_1(bus_1),
        .select_compare(select_compare), .port_enable(port_enable),
        .unit_selected(unit_selected), .busy(busy), .seek_end_n(seek_end_n),
        .failed_attempt_flag(failed_attempt_flag), .port_lockout_flag(port_lockout_flag),
        .reserved(reserved));

    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        compares++;
        if (exp !== seen) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic settle(input int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic end_of_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_select;
        @(posedge clk) cable_present <= 2'h2;
        want_select[0] <= 1'b1;
        settle(40);
        check("compare no cable", 1'b0, select_compare[0]);
        @(posedge clk) cable_present <= 2'h3;
        for (n = 0; n < 40 && unit_selected[0] !== 1'b1; n++) settle(1);
        check("compare", 1'b1, select_compare[0]);
        check("reserve and enable", 2'h3, {reserved[0], port_enable[0]});
        check("unit selected", 1'b1, unit_selected[0]);
    endtask

    task automatic t_refused;
        @(posedge clk) target_1 <= 4'h2;
        want_select[1] <= 1'b1;
        settle(40);
        check("compare mismatch", 2'h0, {select_compare[1], busy[1]});
        @(posedge clk) target_1 <= PLUG;
        for (n = 0; n < 40 && busy[1] !== 1'b1; n++) settle(1);
        check("refused reply", 2'h3, {unit_selected[1], busy[1]});
        check("tried flag", 1'b1, failed_attempt_flag[1]);
        check("no reserve", 1'b0, reserved[1]);
        @(posedge clk) want_select <= 2'h0;
        settle(30);
        check("deselect", 2'h0, {port_enable[0], unit_selected[0]});
        check("kept reserve", 1'b1, reserved[0]);
        @(posedge clk) want_select[1] <= 1'b1;
        for (n = 0; n < 40 && busy[1] !== 1'b1; n++) settle(1);
        check("busy while only reserved", 2'h2, {busy[1], reserved[1]});
        @(posedge clk) want_select[1] <= 1'b0;
        settle(300);
        check("absolute hold", 1'b1, reserved[0]);
    endtask

    task automatic t_timed;
        @(posedge clk) absolute_hold_mode <= 1'b0;
        timed_hold_mode <= 1'b1;
        want_select[0] <= 1'b1;
        for (n = 0; n < 40 && unit_selected[0] !== 1'b1; n++) settle(1);
        @(posedge clk) want_select[0] <= 1'b0;
        settle(150);
        check("reserve before expiry", 1'b1, reserved[0]);
        for (n = 0; n < 100 && seek_end_n[1] !== 1'b0; n++) settle(1);
        check("reserve after expiry", 1'b0, reserved[0]);
        for (n = 0; n < 40 && seek_end_n[1] === 1'b0; n++) settle(1);
        check("notice length", 16'(TRY), 16'(n));
        check("tried cleared", 1'b0, failed_attempt_flag[1]);
    endtask

    task automatic t_release;
        @(posedge clk) want_select[1] <= 1'b1;
        for (n = 0; n < 40 && unit_selected[1] !== 1'b1; n++) settle(1);
        check("second channel reserve", 1'b1, reserved[1]);
        @(posedge clk) want_release[1] <= 1'b1;
        for (n = 0; n < 20 && reserved[1] !== 1'b0; n++) settle(1);
        check("release command", 1'b0, reserved[1]);
        @(posedge clk) want_release[1] <= 1'b0;
        want_select[1] <= 1'b0;
        settle(20);
    endtask

    task automatic t_priority;
        @(posedge clk) want_select[0] <= 1'b1;
        for (n = 0; n < 40 && unit_selected[0] !== 1'b1; n++) settle(1);
        @(posedge clk) want_priority[1] <= 1'b1;
        // the refused-but-owned reply comes first; wait for the new reservation
        for (n = 0; n < 40 && reserved[1] !== 1'b1; n++) settle(1);
        settle(1);
        check("priority lockout", 3'h6, {port_lockout_flag[0], reserved});
        check("priority reply", 2'h2, {unit_selected[1], busy[1]});
        settle(40);
        check("silent refusal", 3'h0, {unit_selected[0], busy[0], select_compare[0]});
        @(posedge clk) want_priority[1] <= 1'b0;
        settle(260);
        check("lockout after expiry", 1'b1, port_lockout_flag[0]);
        @(posedge clk) want_select <= 2'h2;
        for (n = 0; n < 40 && unit_selected[1] !== 1'b1; n++) settle(1);
        @(posedge clk) want_release[1] <= 1'b1;
        for (n = 0; n < 20 && port_lockout_flag[0] !== 1'b0; n++) settle(1);
        check("release clears lockout", 1'b0, port_lockout_flag[0]);
        @(posedge clk) want_release[1] <= 1'b0;
        want_select[1] <= 1'b0;
        settle(20);
    endtask

    task automatic t_maintenance;
        @(posedge clk) first_off <= 1'b1;
        second_off <= 1'b1;
        want_select <= 2'h3;
        settle(40);
        check("switch off", 8'h00, {unit_selected, busy, port_enable, select_compare});
        @(posedge clk) want_select <= 2'h0;
        first_off <= 1'b0;
        second_off <= 1'b0;
        settle(5);
    endtask

    task automatic t_both;
        @(posedge clk) want_select <= 2'h3;
        settle(50);
        check("one winner", 1'b1, port_enable[0] ^ port_enable[1]);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_select();
        t_refused();
        t_timed();
        t_release();
        t_priority();
        t_maintenance();
        t_both();
        end_of_test();
    end
endmodule
